// ==== fpc_cfg.svh ====
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 32-bit APB, byte addresses
// Notes: Definitions only
`ifndef FPC_CFG_SVH
`define FPC_CFG_SVH
`define FPC_OFS_TRIM 8'h00
`define FPC_OFS_CLOCK_DIVISOR_REGISTER 8'h04
`define FPC_OFS_FBD 8'h08
`define FPC_OFS_OSCCTL 8'h0C
`define FPC_PRE_MSB 4
`define FPC_POST_LSB 6
`define FPC_FAST_RC_POSTSCALE_SELECT_LSB 8
`define FPC_LOCK_BIT 5
`define FPC_SWITCH_BIT 0
`define FPC_NEWSRC_LSB 8
`define FPC_CURSRC_LSB 12
`define FPC_PRE_RST 5'h00
`define FPC_POST_RST 2'h1
`define FPC_FAST_RC_POSTSCALE_SELECT_RST 3'h0
`define FPC_FBD_RST 9'h030
`define FPC_TRIM_RST 6'h00
`define FPC_SRC_FRC 3'h0
`define FPC_SRC_FAST_RC_WITH_PLL_MODE 3'h1
`define FPC_SRC_POSC 3'h2
`define FPC_SRC_POSCPLL 3'h3
`define FPC_SRC_DIV16 3'h6
`define FPC_SRC_DIVN 3'h7
`define FPC_DIV16_CODE 3'h4
`define FPC_OST_EDGES 1024
`define FPC_CLK_MHZ 20
`define FPC_LOCK_US 50
`define FPC_LOCK_CYC (`FPC_LOCK_US * `FPC_CLK_MHZ)
`endif

// ==== fpc_pkg.sv ====
// Purpose: Types shared by the clock control files
// Assumes: Constants come from fpc_cfg.svh
// Notes: Types only
package fpc_pkg;
  typedef logic [2:0] fpc_src_t;
  typedef enum logic [1:0] {FPC_IDLE, FPC_OST, FPC_LOCKING, FPC_LOCKED} fpc_lock_st_t;
endpackage

// ==== fpc_lock_if.sv ====
// Purpose: Carries lock control between the controller and the lock timer
// Assumes: Single clock domain
// Notes: start and abort are one-cycle pulses
`timescale 1ns/100ps
interface fpc_lock_if;
  logic start;
  logic abort;
  logic need_ost;
  logic osc_edge;
  logic clk_ready;
  logic locked;
  modport ctl (output start, output abort, output need_ost, output osc_edge,
               input clk_ready, input locked);
  modport tmr (input start, input abort, input need_ost, input osc_edge,
               output clk_ready, output locked);
endinterface // fpc_lock_if

// ==== fpc_postscaler.sv ====
// Purpose: Divides a stream of oscillator edge pulses by a coded ratio
// Assumes: edge_in is a one-cycle pulse per oscillator cycle
// Notes: Codes 0..6 divide by 2**code, code 7 by 256
`timescale 1ns/100ps
`include "fpc_cfg.svh"
module fpc_postscaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic edge_in,
  input wire logic [2:0] sel,
  output logic tick
);
  import fpc_pkg::*;
  logic [7:0] cnt_q;
  logic [7:0] last;
  // Terminal count from the code; code 7 jumps to 255, a divide by 256
  assign last = (sel == 3'h7) ? 8'hFF : 8'((9'h001 << sel) - 9'h001);
  assign tick = edge_in && (cnt_q >= last);
  // Counter restarts on terminal count, so a ratio change settles quickly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
    end else if (edge_in) begin
      cnt_q <= (cnt_q >= last) ? 8'h00 : cnt_q + 8'h01;
    end
  end
endmodule // fpc_postscaler

// ==== fpc_lock_timer.sv ====
// Purpose: Start-up count for the crystal, then lock interval for the PLL
// Assumes: osc_edge pulses once per crystal cycle
// Notes: abort drops the flag at once
`timescale 1ns/100ps
`include "fpc_cfg.svh"
module fpc_lock_timer (
  input wire logic pclk,
  input wire logic presetn,
  fpc_lock_if.tmr lk
);
  import fpc_pkg::*;
  fpc_lock_st_t st_q;
  logic [10:0] ost_q;
  logic [15:0] lck_q;
  assign lk.locked = (st_q == FPC_LOCKED);
  assign lk.clk_ready = (st_q != FPC_OST);
  // Crystal waits its start-up count first; internal RC counts lock at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= FPC_IDLE;
      ost_q <= 11'h000;
      lck_q <= 16'h0000;
    end else if (lk.abort) begin
      st_q <= FPC_IDLE;
    end else if (lk.start) begin
      st_q <= lk.need_ost ? FPC_OST : FPC_LOCKING;
      ost_q <= 11'h000;
      lck_q <= 16'h0000;
    end else begin
      case (st_q)
        FPC_OST: begin
          if (lk.osc_edge) begin
            ost_q <= ost_q + 11'h001;
            if (ost_q == 11'(`FPC_OST_EDGES - 1)) begin
              st_q <= FPC_LOCKING;
            end
          end
        end
        FPC_LOCKING: begin
          lck_q <= lck_q + 16'h0001;
          if (lck_q == 16'(`FPC_LOCK_CYC - 1)) begin
            st_q <= FPC_LOCKED;
          end
        end
        default: st_q <= st_q;
      endcase
    end
  end
endmodule // fpc_lock_timer

// ==== fpc_clock_ctrl.sv ====
// Purpose: Fast RC trim, postscaler, PLL divider and lock control
// Assumes: APB slave on pclk; oscillator edges arrive as pins
// Notes: Analog oscillator and VCO live outside this block
// Operation
// - Six-bit RC trim, 30 kHz steps
// - RC clock usable immediately, no start-up count
// - Reset source codes 111, 110, 001, 000; the strap loads any three-bit code as given
// - Postscaler resets to divide by one
// - Postscaled RC output may feed PLL
// - N1 equals input divide field plus 2
// - M equals feedback field plus 2
// - N2 equals twice output field plus two
// - Output is input times M over N1 N2
// - Reset dividers N1 2, N2 4, M 50
// - Lock interval after PLL-affecting changes
// - Lock count starts when input reaches PLL
// - Read-only lock flag, cleared on PLL switch
// - Crystal start-up timer counts 1024 cycles
`timescale 1ns/100ps
`include "fpc_cfg.svh"
module fpc_clock_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] initial_source_select,
  input wire logic frc_osc_in,
  input wire logic posc_osc_in,
  output logic [5:0] frequency_trim_code,
  output logic frc_enable,
  output logic frc_ready,
  output fpc_pkg::fpc_src_t current_source,
  output logic sys_clk_tick,
  output logic pll_ref_tick,
  output logic pll_selected,
  output logic [5:0] pll_n1,
  output logic [9:0] pll_m,
  output logic [3:0] pll_n2,
  output logic [8:0] pll_n1n2,
  output logic pll_lock
);
  import fpc_pkg::*;

  fpc_lock_if lk ();

  // Two-flop synchronisers on all pins; edge detect compares stage two with stage three
  logic [2:0] strap_s1_q, strap_s2_q;
  logic frc_s1_q, frc_s2_q, frc_s3_q;
  logic posc_s1_q, posc_s2_q, posc_s3_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1_q <= 3'h0;
      strap_s2_q <= 3'h0;
      {frc_s1_q, frc_s2_q, frc_s3_q} <= 3'h0;
      {posc_s1_q, posc_s2_q, posc_s3_q} <= 3'h0;
    end else begin
      strap_s1_q <= initial_source_select;
      strap_s2_q <= strap_s1_q;
      {frc_s1_q, frc_s2_q, frc_s3_q} <= {frc_osc_in, frc_s1_q, frc_s2_q};
      {posc_s1_q, posc_s2_q, posc_s3_q} <= {posc_osc_in, posc_s1_q, posc_s2_q};
    end
  end

  logic frc_edge, posc_edge;
  assign frc_edge = frc_s2_q && !frc_s3_q;
  assign posc_edge = posc_s2_q && !posc_s3_q;

  // Software-visible state
  logic [5:0] trim_q;
  logic [4:0] pre_q;
  logic [1:0] post_q;
  logic [2:0] fast_rc_postscale_select_q;
  logic [8:0] fbd_q;
  fpc_src_t cur_q;
  fpc_src_t nsrc_q;
  logic [1:0] boot_q;
  logic [31:0] rdata_q;

  // APB decode: zero wait states, unmapped address answers with an error
  logic setup_ph, access_ph, wr_en;
  logic hit_trim, hit_div, hit_fbd, hit_osc, hit_any;
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign hit_trim = (paddr == `FPC_OFS_TRIM);
  assign hit_div = (paddr == `FPC_OFS_CLOCK_DIVISOR_REGISTER);
  assign hit_fbd = (paddr == `FPC_OFS_FBD);
  assign hit_osc = (paddr == `FPC_OFS_OSCCTL);
  assign hit_any = hit_trim || hit_div || hit_fbd || hit_osc;
  assign wr_en = access_ph && pwrite && hit_any;
  assign pready = access_ph;
  assign pslverr = access_ph && !hit_any;
  assign prdata = rdata_q;

  // Source classes
  logic cur_pll, dst_pll, switch_req, boot_done, div_wr_pll;
  fpc_src_t dst_src;
  assign dst_src = fpc_src_t'(pwdata[`FPC_NEWSRC_LSB +: 3]);
  assign switch_req = wr_en && hit_osc && pwdata[`FPC_SWITCH_BIT];
  assign cur_pll = (cur_q == `FPC_SRC_FAST_RC_WITH_PLL_MODE) || (cur_q == `FPC_SRC_POSCPLL);
  assign dst_pll = (dst_src == `FPC_SRC_FAST_RC_WITH_PLL_MODE) || (dst_src == `FPC_SRC_POSCPLL);
  assign boot_done = (boot_q == 2'h3);
  // Divider writes under PLL restart the lock rather than trust software
  assign div_wr_pll = cur_pll && wr_en && (hit_div || hit_fbd);

  // Read mux, captured in the setup cycle; lock and source are read-only
  logic [31:0] rd_mux;
  assign rd_mux = hit_trim ? {26'h0, trim_q} :
                  hit_div ? {21'h0, fast_rc_postscale_select_q, post_q, 1'b0, pre_q} :
                  hit_fbd ? {23'h0, fbd_q} :
                  hit_osc ? {17'h0, cur_q, 1'b0, nsrc_q, 2'h0,
                             lk.locked, 5'h00} : 32'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0;
    end else if (setup_ph) begin
      rdata_q <= rd_mux;
    end
  end

  // Trim register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_q <= `FPC_TRIM_RST;
    end else if (wr_en && hit_trim) begin
      trim_q <= pwdata[5:0];
    end
  end

  // Divider registers; reset values give N1 2, N2 4, M 50
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= `FPC_PRE_RST;
      post_q <= `FPC_POST_RST;
      fast_rc_postscale_select_q <= `FPC_FAST_RC_POSTSCALE_SELECT_RST;
    end else if (wr_en && hit_div) begin
      pre_q <= pwdata[`FPC_PRE_MSB:0];
      post_q <= pwdata[`FPC_POST_LSB +: 2];
      fast_rc_postscale_select_q <= pwdata[`FPC_FAST_RC_POSTSCALE_SELECT_LSB +: 3];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fbd_q <= `FPC_FBD_RST;
    end else if (wr_en && hit_fbd) begin
      fbd_q <= pwdata[8:0];
    end
  end

  // Strap is taken at the third edge, when stage two holds the pin, not reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_q <= 2'h0;
      cur_q <= `FPC_SRC_FRC;
      nsrc_q <= `FPC_SRC_FRC;
    end else if (!boot_done) begin
      boot_q <= boot_q + 2'h1;
      if (boot_q == 2'h2) begin
        cur_q <= strap_s2_q;
        nsrc_q <= strap_s2_q;
      end
    end else if (switch_req) begin
      cur_q <= dst_src;
      nsrc_q <= dst_src;
    end
  end

  // Lock control: start on PLL boot or switch, abort on non-PLL switch
  logic boot_pll;
  assign boot_pll = (boot_q == 2'h2) &&
                    ((strap_s2_q == `FPC_SRC_FAST_RC_WITH_PLL_MODE) || (strap_s2_q == `FPC_SRC_POSCPLL));
  assign lk.start = boot_pll || (switch_req && dst_pll) || div_wr_pll;
  assign lk.abort = switch_req && !dst_pll;
  assign lk.need_ost = boot_pll ? (strap_s2_q == `FPC_SRC_POSCPLL)
                                : (div_wr_pll ? (cur_q == `FPC_SRC_POSCPLL)
                                              : (dst_src == `FPC_SRC_POSCPLL));
  assign lk.osc_edge = posc_edge;

  fpc_lock_timer u_lock (
    .pclk(pclk),
    .presetn(presetn),
    .lk(lk)
  );

  // Postscaled RC and fixed divide-by-sixteen
  logic divn_tick, div16_tick;
  fpc_postscaler u_divn (
    .pclk(pclk),
    .presetn(presetn),
    .edge_in(frc_edge),
    .sel(fast_rc_postscale_select_q),
    .tick(divn_tick)
  );
  fpc_postscaler u_div16 (
    .pclk(pclk),
    .presetn(presetn),
    .edge_in(frc_edge),
    .sel(`FPC_DIV16_CODE),
    .tick(div16_tick)
  );

  // Clock selection; RC paths need no start-up gating
  logic ref_sel, sys_sel;
  assign ref_sel = (cur_q == `FPC_SRC_POSCPLL) ? (posc_edge && lk.clk_ready)
                                               : divn_tick;
  assign sys_sel = (cur_q == `FPC_SRC_FRC) ? frc_edge :
                   (cur_q == `FPC_SRC_DIV16) ? div16_tick :
                   (cur_q == `FPC_SRC_DIVN) ? divn_tick :
                   (cur_q == `FPC_SRC_POSC) ? posc_edge : 1'b0;

  // Ratios: N1 = pre+2, M = fbd+2, N2 = 2(post+1)
  logic [5:0] n1_w;
  logic [3:0] n2_w;
  assign n1_w = {1'b0, pre_q} + 6'h02;
  // N2 reaches 8 for field value 3, so it needs four bits
  assign n2_w = {1'b0, post_q, 1'b0} + 4'h2;

  // Registered outputs; divide is left to the analog loop using these ratios
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_clk_tick <= 1'b0;
      pll_ref_tick <= 1'b0;
      pll_n1 <= 6'h00;
      pll_m <= 10'h000;
      pll_n2 <= 4'h0;
      pll_n1n2 <= 9'h000;
    end else begin
      sys_clk_tick <= sys_sel;
      pll_ref_tick <= cur_pll && ref_sel;
      pll_n1 <= n1_w;
      pll_m <= {1'b0, fbd_q} + 10'h002;
      pll_n2 <= n2_w;
      pll_n1n2 <= {3'h0, n1_w} * {5'h00, n2_w};
    end
  end

  assign frequency_trim_code = trim_q;
  assign frc_enable = (cur_q != `FPC_SRC_POSC) && (cur_q != `FPC_SRC_POSCPLL);
  assign frc_ready = frc_enable;
  assign current_source = cur_q;
  assign pll_selected = cur_pll;
  assign pll_lock = lk.locked;
endmodule // fpc_clock_ctrl

// ==== fpc_clock_ctrl_asserts.sv ====
// Purpose: Port-level checks of the clock control block
// Assumes: Bound to fpc_clock_ctrl, one clock domain
// Notes: Ratio outputs lag a register write by one edge
`timescale 1ns/100ps
`include "fpc_cfg.svh"
module fpc_clock_ctrl_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [5:0] frequency_trim_code,
  input wire logic frc_enable,
  input wire logic frc_ready,
  input wire logic [2:0] current_source,
  input wire logic pll_ref_tick,
  input wire logic pll_selected,
  input wire logic [5:0] pll_n1,
  input wire logic [9:0] pll_m,
  input wire logic [3:0] pll_n2,
  input wire logic [8:0] pll_n1n2,
  input wire logic pll_lock
);
  import fpc_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Write strobes as the slave takes them
  wire wr_acc = psel && penable && pwrite;
  wire wr_div = wr_acc && paddr == `FPC_OFS_CLOCK_DIVISOR_REGISTER;
  sequence sw_to_fast_rc_with_pll_mode;
    wr_acc && paddr == `FPC_OFS_OSCCTL && pwdata[0] && pwdata[10:8] == 3'h1;
  endsequence
  // Ratios looked at two edges on; no later write can have landed by then
  trim_load_a: assert property (wr_acc && paddr == `FPC_OFS_TRIM |=>
    frequency_trim_code == $past(pwdata[5:0])) else $error("trim code not loaded");
  n1_ratio_a: assert property (wr_div |=> ##1
    pll_n1 == $past(pwdata[4:0], 2) + 6'h02) else $error("input ratio wrong");
  m_ratio_a: assert property (wr_acc && paddr == `FPC_OFS_FBD |=> ##1
    pll_m == $past(pwdata[8:0], 2) + 10'h002) else $error("feedback ratio wrong");
  n2_ratio_a: assert property (wr_div |=> ##1
    pll_n2 == {1'b0, $past(pwdata[7:6], 2), 1'b0} + 4'h2) else $error("output ratio wrong");
  ratio_product_a: assert property (pll_n1n2 == pll_n1 * pll_n2)
    else $error("ratio product wrong");
  // RC is wanted by every source but the crystal ones, and is ready with it
  rc_ready_a: assert property (frc_ready == frc_enable && frc_enable ==
    !(current_source == `FPC_SRC_POSC || current_source == `FPC_SRC_POSCPLL))
    else $error("rc clock not ready at once");
  lock_hold_a: assert property (sw_to_fast_rc_with_pll_mode |=> !pll_lock [*8])
    else $error("lock flag not cleared by switch");
  lock_off_a: assert property (!pll_selected |-> !pll_lock)
    else $error("lock set off the pll");
  lock_source_a: assert property ($rose(pll_lock) |-> pll_selected)
    else $error("lock rose without pll source");
  ref_idle_a: assert property (!pll_selected && !$past(pll_selected) |->
    !pll_ref_tick) else $error("pll input ticks off the pll");
endmodule // fpc_clock_ctrl_asserts
bind fpc_clock_ctrl fpc_clock_ctrl_asserts u_chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .frequency_trim_code(frequency_trim_code),
  .frc_enable(frc_enable),
  .frc_ready(frc_ready),
  .current_source(current_source),
  .pll_ref_tick(pll_ref_tick),
  .pll_selected(pll_selected),
  .pll_n1(pll_n1),
  .pll_m(pll_m),
  .pll_n2(pll_n2),
  .pll_n1n2(pll_n1n2),
  .pll_lock(pll_lock)
);

// ==== fpc_testbench.sv ====
// Purpose: Self-checking bench for the clock control block
// Assumes: RC pin toggles every cycle, crystal pin is random
// Notes: Register model is masked words in an int array
`timescale 1ns/100ps
`include "fpc_cfg.svh"
module testbench;
  import fpc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic frc_osc_in = 1'b0, posc_osc_in = 1'b0, pready, pslverr, er;
  logic frc_enable, frc_ready, sys_clk_tick, pll_ref_tick, pll_selected, pll_lock;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, rs = 32'hAC94;
  logic [2:0] initial_source_select = 3'h0;
  logic [3:0] pll_n2;
  logic [1:0] posc_h = 2'h0;
  logic [5:0] frequency_trim_code, pll_n1;
  logic [9:0] pll_m;
  logic [8:0] pll_n1n2;
  fpc_src_t current_source;
  logic [2:0] sc[4] = '{3'h7, 3'h6, 3'h1, 3'h0};
  int err_count = 0, n_tests = 0, mreg[4], msk[3] = '{32'h3F, 32'h7DF, 32'h1FF};
  fpc_clock_ctrl dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .initial_source_select(initial_source_select),
    .frc_osc_in(frc_osc_in),
    .posc_osc_in(posc_osc_in),
    .frequency_trim_code(frequency_trim_code),
    .frc_enable(frc_enable),
    .frc_ready(frc_ready),
    .current_source(current_source),
    .sys_clk_tick(sys_clk_tick),
    .pll_ref_tick(pll_ref_tick),
    .pll_selected(pll_selected),
    .pll_n1(pll_n1),
    .pll_m(pll_m),
    .pll_n2(pll_n2),
    .pll_n1n2(pll_n1n2),
    .pll_lock(pll_lock)
  );
  always #25 pclk = ~pclk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // RC pin runs free at half rate; crystal edges come at random spacing
  always @(posedge pclk) begin
    frc_osc_in <= ~frc_osc_in;
    rs <= xs(rs);
    posc_osc_in <= rs[7];
    posc_h <= {posc_h[0], posc_osc_in}; // Pin history for edges already in flight
  end
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request stands until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic boot(input logic [2:0] s);
    presetn <= 1'b0;
    initial_source_select <= s;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  // Spacing of ticks; the first interval after a change may be partial
  task automatic per(input logic r, output int n);
    n = 0;
    repeat (2) do @(posedge pclk); while ((r ? pll_ref_tick : sys_clk_tick) !== 1'b1);
    do begin
      @(posedge pclk);
      n++;
    end while ((r ? pll_ref_tick : sys_clk_tick) !== 1'b1);
  endtask
  // Cycles to lock, and the cycle of the 1024th crystal edge if any
  task automatic lock_wait(output int n, output int k);
    int e;
    logic p;
    n = 0;
    k = 0;
    // Two pin edges seen just before the switch are still in the synchroniser
    e = int'(posc_h[0] & !posc_h[1]) + int'(posc_osc_in & !posc_h[0]);
    p = posc_osc_in;
    while (pll_lock !== 1'b1) begin
      @(posedge pclk);
      n++;
      e += int'(posc_osc_in & !p);
      if (e == `FPC_OST_EDGES && k == 0)
        k = n;
      p = posc_osc_in;
    end
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    err_count++;
    tally_and_finish();
  end
  initial begin
    int n, k;
    logic [31:0] v;
    // Each of the four listed power-on codes comes up with the divider defaults
    foreach (sc[i]) begin
      boot(sc[i]);
      chk(current_source, sc[i]);
      chk({frc_enable, frc_ready}, 2'h3);
      chk({pll_n1, pll_m, pll_n2, pll_n1n2}, {6'h02, 10'h032, 4'h4, 9'h008});
      apb(1'b0, `FPC_OFS_OSCCTL, 0);
      chk(rd & 32'h7021, {sc[i], 12'h000});
      apb(1'b0, `FPC_OFS_CLOCK_DIVISOR_REGISTER, 0);
      chk(rd, 32'h40);
      apb(1'b0, `FPC_OFS_FBD, 0);
      chk(rd, 32'h30);
    end
    // Arbitrary settings while off the PLL; a refused write must not land
    repeat (6) begin
      for (int i = 0; i < 3; i++) begin
        v = rs;
        apb(1'b1, 8'(i * 4), v);
        mreg[i] = v & msk[i];
      end
      apb(1'b1, 8'h10, rs);
      chk(er, 1'b1);
      for (int i = 0; i < 4; i++) begin
        apb(1'b0, 8'(i * 4), 0);
        chk(rd, mreg[i]);
      end
      chk(pll_n1, mreg[1][4:0] + 2);
      chk(pll_m, mreg[2][8:0] + 2);
      chk(pll_n2, 2 * (mreg[1][7:6] + 1));
      chk(pll_n1n2, (mreg[1][4:0] + 2) * 2 * (mreg[1][7:6] + 1));
      chk(frequency_trim_code, mreg[0]);
    end
    // Every postscaler code on the postscaled source
    apb(1'b1, `FPC_OFS_OSCCTL, 32'h701);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, `FPC_OFS_CLOCK_DIVISOR_REGISTER, {c[2:0], 8'h40});
      per(1'b0, n);
      chk(n, 2 * (c == 7 ? 256 : 1 << c));
    end
    apb(1'b1, `FPC_OFS_OSCCTL, 32'h601);
    per(1'b0, n);
    chk(n, 32);
    apb(1'b1, `FPC_OFS_OSCCTL, 32'h001);
    per(1'b0, n);
    chk(n, 2);
    // Reprogram off the PLL, then switch to RC with PLL
    apb(1'b1, `FPC_OFS_CLOCK_DIVISOR_REGISTER, 32'h140);
    apb(1'b1, `FPC_OFS_OSCCTL, 32'h101);
    lock_wait(n, k);
    chk(n >= `FPC_LOCK_CYC && n <= `FPC_LOCK_CYC + 4, 1'b1);
    per(1'b1, n);
    chk(n, 4);
    apb(1'b1, `FPC_OFS_OSCCTL, 32'h100);
    apb(1'b0, `FPC_OFS_OSCCTL, 0);
    chk(rd, 32'h1120);
    // Crystal with PLL waits out the start-up count first
    apb(1'b1, `FPC_OFS_OSCCTL, 32'h001);
    apb(1'b1, `FPC_OFS_OSCCTL, 32'h301);
    lock_wait(n, k);
    chk(k > 0 && n - k >= `FPC_LOCK_CYC - 12 && n - k <= `FPC_LOCK_CYC + 12, 1'b1);
    tally_and_finish();
  end
endmodule // testbench
